// [hdl/cppsc_coord.sv]
// Purpose: Per-core C-state machines and package state coordination
// Assumes: Requests are one-cycle pulses synchronous to mclk
// Notes: One state machine per core feeds a shared package coordinator
// Overview of operation
// - Cores sleep independently; common state triggers matching package level read.
// - Level reads become internal wait requests, never bus I/O reads.
// - Level reads need no armed monitor address.
// - Level-read hint comes from misc_enable_config fields.
// - Break event during stop-clock asserts pending-break output.
// - Package follows shallower core: Normal, Stop-Grant or Deep Sleep.
// - Both cores in C4 request the deepest voltage-reduced package state.
// - Halt enters C1; SMI, init, local lines or bus interrupt wake to C0.
// - Reset in any low-power state initialises the core at once.
// - Management interrupt exit resumes Normal or halt state.
// - Stop-clock deassert during halt returns core to halt.
// - Halt C1 services snoops in a snoopable sub-state then returns.
// - Wait C1 behaves like halt C1; monitor event also wakes.
// - Level-2 read or wait C2 enters C2; acknowledge only under stop-clock.
// - C2 services snoops through a snoopable sub-state then returns.
// - C3 entry via level-3 read or wait C3, after L1 flush.
// - C3 keeps state, keeps monitor armed, stops core clocks.
// - C3 ignores bus snoops and other-core cacheable accesses.
// - C3 wakes on monitor, SMI, init, local lines or bus interrupt.
// - C4 via level-4/5 read or wait C4, else like C3.
// - Enhanced deep state allowed only with cache sizing and enhanced bits.
// - C6 saves context to own storage; core supply may drop.
// - Under stop-clock, Stop-Grant within 20 bus clocks of acknowledge.
// - Pending-break asserts under stop-clock for any latched interrupt or monitor event.
module cppsc_coord #(
    parameter int unsigned NCORES = 2,
    parameter int unsigned BCLK_DIV = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cppsc_pkg::cppsc_req_s [NCORES-1:0] core_req,
    input wire cppsc_pkg::cppsc_wake_s [NCORES-1:0] core_wake,
    input wire logic [NCORES-1:0] smm_resume_halt,
    input wire logic [NCORES-1:0] bus_snoop,
    input wire logic [NCORES-1:0] peer_snoop,
    input wire logic [NCORES-1:0] flush_done,
    input wire logic [NCORES-1:0] snoop_done,
    input wire logic [NCORES-1:0] ctx_wr,
    input wire logic [NCORES-1:0][cppsc_pkg::CTX_AW-1:0] ctx_addr,
    input wire logic [NCORES-1:0][31:0] ctx_wdata,
    input wire logic [cppsc_pkg::MISC_W-1:0] misc_enable_config,
    input wire logic [cppsc_pkg::CST_W-1:0] cstate_config_control,
    input wire logic stop_clock_request_n,
    input wire logic level_read_ack,
    output logic pending_break_event_n,
    output logic power_level_read,
    output logic [2:0] power_level_code,
    output cppsc_pkg::cppsc_pkg_e package_state,
    output logic [NCORES-1:0] stop_grant_ack,
    output logic [NCORES-1:0] in_stop_grant,
    output logic [NCORES-1:0] core_clock_stop,
    output logic [NCORES-1:0] flush_l1_req,
    output logic [NCORES-1:0] core_supply_off,
    output logic [NCORES-1:0][2:0] core_state_out
);
    import cppsc_pkg::*;

    localparam int unsigned SG_CYC = SG_ENTRY_BCLKS * BCLK_DIV;
    localparam int unsigned SGW = $clog2(SG_CYC + 1);

    cppsc_core_e cstate_r [NCORES];
    logic [2:0] target_r [NCORES];
    logic [2:0] ret_r [NCORES];
    logic [NCORES-1:0] halted_r;
    logic [NCORES-1:0] pend_r;
    logic [NCORES-1:0] sg_ack_r;
    logic [NCORES-1:0] sg_in_r;
    logic [SGW-1:0] sg_cnt_r [NCORES];
    logic [31:0] ctx_mem [NCORES][CTX_WORDS];
    logic [2:0] last_code_r;
    logic pbe_n_r;
    logic lvl_rd_r;
    logic [2:0] lvl_code_r;
    cppsc_pkg_e pkg_r;
    logic [NCORES-1:0] clk_stop_r;
    logic [NCORES-1:0] flush_r;
    logic [NCORES-1:0] supply_off_r;
    logic [NCORES-1:0][2:0] state_out_r;

    // Maps a level index to the configured wait hint
    function automatic logic [2:0] lvl_hint(input logic [2:0] idx, input logic [MISC_W-1:0] cfg);
        logic [2:0] off;
        off = idx - LVL_BASE;
        lvl_hint = cfg[off*HINT_W +: HINT_W];
    endfunction

    // Depth of a state, treating sub-states as their parent
    function automatic logic [2:0] depth(input cppsc_core_e s, input logic [2:0] ret);
        unique case (s)
            CPPSC_C0: depth = 3'h0;
            CPPSC_C1: depth = HINT_C1;
            CPPSC_C2: depth = HINT_C2;
            CPPSC_C3: depth = HINT_C3;
            CPPSC_C4: depth = HINT_C4;
            CPPSC_C6: depth = HINT_C6;
            CPPSC_FLUSH: depth = 3'h0;
            CPPSC_SNOOP: depth = ret;
        endcase
    endfunction

    function automatic logic any_wake(input cppsc_wake_s w);
        any_wake = w.smi | w.init | w.lint | w.bus_intr;
    endfunction

    wire stop_clk = ~stop_clock_request_n;

    genvar g;
    generate
        for (g = 0; g < NCORES; g++) begin : g_core
            logic [2:0] want;
            always_comb begin
                want = 3'h0;
                if (core_req[g].halt)
                    want = HINT_C1;
                else if (core_req[g].wait_req)
                    want = core_req[g].wait_hint;
                else if (core_req[g].level_read)
                    want = lvl_hint(core_req[g].level_idx, misc_enable_config);
            end

            // Core state machine
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    cstate_r[g] <= CPPSC_C0;
                    target_r[g] <= 3'h0;
                    ret_r[g] <= 3'h0;
                    halted_r[g] <= 1'b0;
                end else begin
                    unique case (cstate_r[g])
                        CPPSC_C0: begin
                            if (core_wake[g].smi) begin
                                halted_r[g] <= 1'b0;
                            end else if (want == HINT_C1 || want == HINT_C2) begin
                                cstate_r[g] <= (want == HINT_C1) ? CPPSC_C1 : CPPSC_C2;
                                halted_r[g] <= core_req[g].halt;
                            end else if (want >= HINT_C3 && want <= HINT_C6) begin
                                target_r[g] <= want;
                                cstate_r[g] <= CPPSC_FLUSH;
                            end else if (smm_resume_halt[g]) begin
                                cstate_r[g] <= CPPSC_C1;
                                halted_r[g] <= 1'b1;
                            end
                        end
                        CPPSC_FLUSH: begin
                            if (flush_done[g]) begin
                                unique case (target_r[g])
                                    HINT_C3: cstate_r[g] <= CPPSC_C3;
                                    HINT_C6: cstate_r[g] <= CPPSC_C6;
                                    default: cstate_r[g] <= CPPSC_C4;
                                endcase
                            end
                        end
                        CPPSC_C1, CPPSC_C2: begin
                            if (any_wake(core_wake[g]) ||
                                    (!halted_r[g] && core_wake[g].monitor)) begin
                                cstate_r[g] <= CPPSC_C0;
                            end else if (bus_snoop[g] || peer_snoop[g]) begin
                                ret_r[g] <= depth(cstate_r[g], 3'h0);
                                cstate_r[g] <= CPPSC_SNOOP;
                            end
                        end
                        CPPSC_SNOOP: begin
                            if (snoop_done[g])
                                cstate_r[g] <= (ret_r[g] == HINT_C1) ? CPPSC_C1 : CPPSC_C2;
                        end
                        default: begin
                            // C3, C4, C6: snoops ignored, caches already flushed
                            if (any_wake(core_wake[g]) || core_wake[g].monitor)
                                cstate_r[g] <= CPPSC_C0;
                        end
                    endcase
                end
            end

            // Latched break events
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn)
                    pend_r[g] <= 1'b0;
                else if (any_wake(core_wake[g]) || core_wake[g].monitor)
                    pend_r[g] <= 1'b1;
                else if (cstate_r[g] == CPPSC_C0 && stop_clock_request_n)
                    pend_r[g] <= 1'b0;
            end

            // Stop-grant acknowledge and entry timer
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    sg_ack_r[g] <= 1'b0;
                    sg_in_r[g] <= 1'b0;
                    sg_cnt_r[g] <= '0;
                end else if (!stop_clk) begin
                    sg_ack_r[g] <= 1'b0;
                    sg_in_r[g] <= 1'b0;
                    sg_cnt_r[g] <= '0;
                end else if (!sg_ack_r[g]) begin
                    sg_ack_r[g] <= 1'b1;
                    sg_cnt_r[g] <= SGW'(SG_CYC - 1);
                end else if (sg_cnt_r[g] != '0) begin
                    sg_cnt_r[g] <= sg_cnt_r[g] - 1'b1;
                end else begin
                    sg_in_r[g] <= 1'b1;
                end
            end

            // Context save storage on the I/O plane
            always_ff @(posedge mclk) begin
                if (ctx_wr[g] && cstate_r[g] == CPPSC_FLUSH && target_r[g] == HINT_C6)
                    ctx_mem[g][ctx_addr[g]] <= ctx_wdata[g];
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    clk_stop_r[g] <= 1'b0;
                    flush_r[g] <= 1'b0;
                    supply_off_r[g] <= 1'b0;
                    state_out_r[g] <= 3'h0;
                end else begin
                    clk_stop_r[g] <= (cstate_r[g] == CPPSC_C3) || (cstate_r[g] == CPPSC_C4) ||
                        (cstate_r[g] == CPPSC_C6);
                    flush_r[g] <= (cstate_r[g] == CPPSC_FLUSH) && !flush_done[g];
                    supply_off_r[g] <= (cstate_r[g] == CPPSC_C6);
                    state_out_r[g] <= depth(cstate_r[g], ret_r[g]);
                end
            end
        end
    endgenerate

    // Package coordination from the shallower core
    logic [2:0] min_d;
    logic [2:0] pkg_code;
    cppsc_pkg_e pkg_nxt;
    always_comb begin
        min_d = 3'h7;
        for (int i = 0; i < NCORES; i++) begin
            if (depth(cstate_r[i], ret_r[i]) < min_d)
                min_d = depth(cstate_r[i], ret_r[i]);
        end
        pkg_code = min_d;
        if (min_d <= HINT_C1) begin
            pkg_nxt = CPPSC_PKG_NORMAL;
            pkg_code = 3'h0;
        end else if (min_d == HINT_C2) begin
            pkg_nxt = CPPSC_PKG_STOPGRANT;
        end else if (min_d == HINT_C3) begin
            pkg_nxt = CPPSC_PKG_DEEPSLEEP;
        end else if (cstate_control_ok()) begin
            pkg_nxt = CPPSC_PKG_DEEPER;
        end else begin
            pkg_nxt = CPPSC_PKG_DEEPER;
            pkg_code = HINT_C4;
        end
    end

    function automatic logic cstate_control_ok();
        cstate_control_ok = cstate_config_control[CST_DCS_BIT] &
            cstate_config_control[CST_EDS_BIT];
    endfunction

    // One level read per change to a non-zero package level code
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pkg_r <= CPPSC_PKG_NORMAL;
            last_code_r <= 3'h0;
            lvl_rd_r <= 1'b0;
            lvl_code_r <= 3'h0;
        end else begin
            pkg_r <= pkg_nxt;
            if (lvl_rd_r) begin
                if (level_read_ack)
                    lvl_rd_r <= 1'b0;
            end else if (pkg_code != last_code_r) begin
                last_code_r <= pkg_code;
                if (pkg_code != 3'h0) begin
                    lvl_rd_r <= 1'b1;
                    lvl_code_r <= pkg_code;
                end
            end
        end
    end

    // Pending break only while stop-clock holds
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            pbe_n_r <= 1'b1;
        else
            pbe_n_r <= ~(stop_clk && (|pend_r));
    end

    assign pending_break_event_n = pbe_n_r;
    assign power_level_read = lvl_rd_r;
    assign power_level_code = lvl_code_r;
    assign package_state = pkg_r;
    assign stop_grant_ack = sg_ack_r;
    assign in_stop_grant = sg_in_r;
    assign core_clock_stop = clk_stop_r;
    assign flush_l1_req = flush_r;
    assign core_supply_off = supply_off_r;
    assign core_state_out = state_out_r;
endmodule

// [hdl/cppsc_pkg.sv]
// Purpose: Shared types and constants for the core and package power-state coordinator
// Assumes: One clock, mclk at 250 MHz
// Notes: Package state and level codes are driven on plain ports
package cppsc_pkg;
    localparam int unsigned MCLK_MHZ = 250;
    localparam int unsigned SG_ENTRY_BCLKS = 20;
    localparam int unsigned CTX_WORDS = 16;
    localparam int unsigned CTX_AW = 4;

    typedef enum logic [2:0] {
        CPPSC_C0 = 3'b000,
        CPPSC_C1 = 3'b001,
        CPPSC_C2 = 3'b010,
        CPPSC_C3 = 3'b011,
        CPPSC_C4 = 3'b100,
        CPPSC_C6 = 3'b101,
        CPPSC_FLUSH = 3'b110,
        CPPSC_SNOOP = 3'b111
    } cppsc_core_e;

    typedef enum logic [1:0] {
        CPPSC_PKG_NORMAL = 2'b00,
        CPPSC_PKG_STOPGRANT = 2'b01,
        CPPSC_PKG_DEEPSLEEP = 2'b10,
        CPPSC_PKG_DEEPER = 2'b11
    } cppsc_pkg_e;

    // Requested depth: 0 none, 1 C1, 2 C2, 3 C3, 4 C4, 6 C6
    typedef struct packed {
        logic halt;
        logic wait_req;
        logic [2:0] wait_hint;
        logic level_read;
        logic [2:0] level_idx;
    } cppsc_req_s;

    typedef struct packed {
        logic smi;
        logic init;
        logic lint;
        logic bus_intr;
        logic monitor;
    } cppsc_wake_s;

    // Per-level hint fields in misc_enable_config: 3 bits each, levels 2..6
    localparam int unsigned HINT_W = 3;
    localparam int unsigned MISC_W = 15;
    localparam logic [2:0] LVL_BASE = 3'h2;
    localparam logic [2:0] HINT_C1 = 3'h1;
    localparam logic [2:0] HINT_C2 = 3'h2;
    localparam logic [2:0] HINT_C3 = 3'h3;
    localparam logic [2:0] HINT_C4 = 3'h4;
    localparam logic [2:0] HINT_C6 = 3'h6;
    localparam int unsigned CST_DCS_BIT = 0;
    localparam int unsigned CST_EDS_BIT = 1;
    localparam int unsigned CST_W = 2;
endpackage

// [verification/cppsc_coord_props.sv]
// Purpose: Port checks for the core and package power-state coordinator
// Assumes: One mclk domain, resetn active low
// Notes: Per-core relations are watched on core 0
module cppsc_coord_props
    import cppsc_pkg::*;
#(
    parameter int unsigned NCORES = 2,
    parameter int unsigned BCLK_DIV = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cppsc_pkg::cppsc_wake_s [NCORES-1:0] core_wake,
    input wire logic stop_clock_request_n,
    input wire logic level_read_ack,
    input wire logic pending_break_event_n,
    input wire logic power_level_read,
    input wire cppsc_pkg::cppsc_pkg_e package_state,
    input wire logic [NCORES-1:0] stop_grant_ack,
    input wire logic [NCORES-1:0] in_stop_grant,
    input wire logic [NCORES-1:0] core_clock_stop,
    input wire logic [NCORES-1:0] core_supply_off,
    input wire logic [NCORES-1:0][2:0] core_state_out
);
    localparam int SG_MAX = 20 * BCLK_DIV + 8;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    function automatic cppsc_pkg_e pkg_of(logic [2:0] a, logic [2:0] b);
        logic [2:0] m;
        m = (a < b) ? a : b;
        if (m >= 3'h4) return CPPSC_PKG_DEEPER;
        if (m == 3'h3) return CPPSC_PKG_DEEPSLEEP;
        if (m == 3'h2) return CPPSC_PKG_STOPGRANT;
        return CPPSC_PKG_NORMAL;
    endfunction

    AST_LVL_HOLD: assert property (power_level_read && !level_read_ack |=> power_level_read)
        else $error("level read dropped before acknowledge");
    AST_LVL_PKG: assert property ($rose(power_level_read) |-> package_state != CPPSC_PKG_NORMAL)
        else $error("level read issued while package normal");
    AST_PKG_MAP: assert property (stop_clock_request_n && $stable(core_state_out) [*3]
        |-> package_state == pkg_of(core_state_out[0], core_state_out[1]))
        else $error("package state does not follow shallower core");
    AST_SGA_STOP_CLOCK_REQUEST_N: assert property ($rose(stop_grant_ack[0])
        |-> !stop_clock_request_n || !$past(stop_clock_request_n))
        else $error("stop grant acknowledge without stop clock");
    AST_SG_TIME: assert property ($rose(stop_grant_ack[0])
        |-> ##[0:SG_MAX] (in_stop_grant[0] || stop_clock_request_n))
        else $error("stop grant not entered in time");
    AST_PBE_SRC: assert property ($fell(pending_break_event_n)
        |-> !$past(stop_clock_request_n) || !$past(stop_clock_request_n, 2))
        else $error("pending break raised without stop clock");
    AST_CLK_STOP: assert property (core_clock_stop[0] |-> core_state_out[0] inside {3'h3, 3'h4, 3'h6})
        else $error("core clock stopped outside deep states");
    AST_SUPPLY: assert property (core_supply_off[0] |-> core_state_out[0] == 3'h6)
        else $error("core supply off outside C6");
    AST_C1_WAKE: assert property (core_state_out[0] == 3'h1 && core_wake[0].smi
        |-> ##[1:3] core_state_out[0] == 3'h0)
        else $error("halted core missed wake");

    cover property ($rose(power_level_read));
    cover property (package_state == CPPSC_PKG_DEEPER);
    cover property ($fell(pending_break_event_n));
endmodule

bind cppsc_coord cppsc_coord_props #(.NCORES(NCORES), .BCLK_DIV(BCLK_DIV)) u_cppsc_coord_props (
    .mclk(mclk), .resetn(resetn), .core_wake(core_wake),
    .stop_clock_request_n(stop_clock_request_n), .level_read_ack(level_read_ack),
    .pending_break_event_n(pending_break_event_n), .power_level_read(power_level_read),
    .package_state(package_state), .stop_grant_ack(stop_grant_ack),
    .in_stop_grant(in_stop_grant), .core_clock_stop(core_clock_stop),
    .core_supply_off(core_supply_off), .core_state_out(core_state_out));

// [verification/cppsc_hub_model.sv]
// Purpose: Chipset-side responder to package level reads
// Assumes: Level read is held until acknowledged
// Notes: slow stretches the answer to several cycles
module cppsc_hub_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic power_level_read,
    output logic level_read_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            level_read_ack <= 1'b0;
        end else if (power_level_read && !level_read_ack) begin
            cnt <= cnt + 1;
            level_read_ack <= (cnt >= (slow ? 6 : 0));
        end else begin
            cnt <= 0;
            level_read_ack <= 1'b0;
        end
    end
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the power-state coordinator
// Assumes: Two cores, four mclk per bus clock
// Notes: Flush and snoop completion are echoed back by the bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cppsc_pkg::*;
    localparam int BDIV = 4;
    localparam cppsc_req_s NR = '0;
    localparam cppsc_wake_s NW = '0;
    logic mclk, resetn, stop_clock_request_n, level_read_ack, slow;
    cppsc_req_s [1:0] core_req;
    cppsc_wake_s [1:0] core_wake;
    logic [1:0] bus_snoop, flush_done, snoop_done, stop_grant_ack, in_stop_grant;
    logic [1:0] smm_resume_halt, peer_snoop;
    logic [1:0] core_clock_stop, flush_l1_req, core_supply_off;
    logic [1:0][2:0] core_state_out;
    logic [14:0] misc_enable_config;
    logic [1:0] cstate_config_control;
    logic pending_break_event_n, power_level_read;
    logic [2:0] power_level_code, last_code;
    cppsc_pkg_e package_state;
    int error_cnt, samples_checked, rd_cnt, n;

    cppsc_coord #(.NCORES(2), .BCLK_DIV(BDIV)) u_cppsc_coord (
        .mclk(mclk), .resetn(resetn), .core_req(core_req), .core_wake(core_wake),
        .smm_resume_halt(smm_resume_halt), .bus_snoop(bus_snoop), .peer_snoop(peer_snoop),
        .flush_done(flush_done), .snoop_done(snoop_done), .ctx_wr(2'h0), .ctx_addr('0),
        .ctx_wdata('0), .misc_enable_config(misc_enable_config),
        .cstate_config_control(cstate_config_control),
        .stop_clock_request_n(stop_clock_request_n), .level_read_ack(level_read_ack),
        .pending_break_event_n(pending_break_event_n), .power_level_read(power_level_read),
        .power_level_code(power_level_code), .package_state(package_state),
        .stop_grant_ack(stop_grant_ack), .in_stop_grant(in_stop_grant),
        .core_clock_stop(core_clock_stop), .flush_l1_req(flush_l1_req),
        .core_supply_off(core_supply_off), .core_state_out(core_state_out));
    cppsc_hub_model u_cppsc_hub_model (.mclk(mclk), .resetn(resetn), .slow(slow),
        .power_level_read(power_level_read), .level_read_ack(level_read_ack));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Completion echoes and a log of finished level reads
    always @(posedge mclk) begin
        flush_done <= flush_l1_req & ~flush_done;
        snoop_done <= bus_snoop | peer_snoop;
        if (power_level_read && level_read_ack) begin
            rd_cnt <= rd_cnt + 1;
            last_code <= power_level_code;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(logic [1:0] m, cppsc_req_s r, cppsc_wake_s w, logic [1:0] snp);
        @(posedge mclk);
        for (int c = 0; c < 2; c++) begin
            core_req[c] <= m[c] ? r : NR;
            core_wake[c] <= m[c] ? w : NW;
        end
        bus_snoop <= snp;
        @(posedge mclk);
        core_req <= '0;
        core_wake <= '0;
        bus_snoop <= 2'h0;
        step(12);
    endtask

    function automatic cppsc_req_s rq(int h, int w, int hn, int l, int ix);
        return '{h[0], w[0], hn[2:0], l[0], ix[2:0]};
    endfunction

    task automatic t_c1();
        for (int i = 1; i < 5; i++) begin
            pulse(2'b01, rq(1, 0, 0, 0, 0), NW, 2'h0);
            chk("halt pkg", package_state, CPPSC_PKG_NORMAL);
            pulse(2'b01, NR, NW, 2'h1);
            chk("halt snoop", core_state_out[0], 3'h1);
            pulse(2'b01, NR, cppsc_wake_s'(5'h01), 2'h0);
            chk("halt monitor", core_state_out[0], 3'h1);
            pulse(2'b01, NR, cppsc_wake_s'(5'h01 << i), 2'h0);
            chk("halt wake", core_state_out[0], 3'h0);
            chk("no break", pending_break_event_n, 1'b1);
        end
        pulse(2'b01, rq(0, 1, HINT_C1, 0, 0), NW, 2'h0);
        pulse(2'b01, NR, cppsc_wake_s'(5'h01), 2'h0);
        chk("wait c1 monitor", core_state_out[0], 3'h0);
        @(posedge mclk) smm_resume_halt <= 2'h1;
        @(posedge mclk) smm_resume_halt <= 2'h0;
        step(4);
        chk("smm resume", core_state_out[0], 3'h1);
        pulse(2'b01, NR, cppsc_wake_s'(5'h01), 2'h0);
        chk("smm halt monitor", core_state_out[0], 3'h1);
        $display("test c1 done");
    endtask

    task automatic t_c2();
        pulse(2'b01, rq(1, 0, 0, 0, 0), NW, 2'h0);
        @(posedge mclk) stop_clock_request_n <= 1'b0;
        step(10);
        @(posedge mclk) stop_clock_request_n <= 1'b1;
        step(10);
        chk("halt after stop clock", core_state_out[0], 3'h1);
        pulse(2'b01, NR, cppsc_wake_s'(5'h10), 2'h0);
        pulse(2'b01, rq(0, 0, 0, 1, 3'h2), NW, 2'h0);
        pulse(2'b01, NR, NW, 2'h1);
        @(posedge mclk) peer_snoop <= 2'h1;
        @(posedge mclk) peer_snoop <= 2'h0;
        step(4);
        chk("c2 after snoop", core_state_out[0], 3'h2);
        chk("no ack", stop_grant_ack, 2'h0);
        pulse(2'b10, rq(0, 1, HINT_C2, 0, 0), NW, 2'h0);
        chk("c2 pkg", package_state, CPPSC_PKG_STOPGRANT);
        chk("c2 code", last_code, 3'h2);
        @(posedge mclk) stop_clock_request_n <= 1'b0;
        n = 0;
        while (in_stop_grant[0] !== 1'b1) begin
            step(1);
            n++;
            if (n > 20 * BDIV + 8) begin
                chk("stop grant entry", in_stop_grant[0], 1'b1);
                wrap_up();
            end
        end
        chk("stop grant ack", stop_grant_ack[0], 1'b1);
        pulse(2'b01, NR, cppsc_wake_s'(5'h02), 2'h0);
        chk("break", pending_break_event_n, 1'b0);
        @(posedge mclk) stop_clock_request_n <= 1'b1;
        pulse(2'b10, NR, cppsc_wake_s'(5'h04), 2'h0);
        chk("break clear", pending_break_event_n, 1'b1);
        chk("cores awake", core_state_out, 6'h0);
        $display("test c2 done");
    endtask

    task automatic t_deep();
        @(posedge mclk) misc_enable_config <= 15'h6912;
        pulse(2'b01, rq(0, 0, 0, 1, 3'h3), NW, 2'h0);
        chk("hint remap", core_state_out[0], 3'h2);
        pulse(2'b01, NR, cppsc_wake_s'(5'h08), 2'h0);
        @(posedge mclk) misc_enable_config <= 15'h691a;
        n = rd_cnt;
        pulse(2'b11, rq(0, 0, 0, 1, 3'h3), NW, 2'h0);
        pulse(2'b11, NR, NW, 2'h3);
        @(posedge mclk) peer_snoop <= 2'h3;
        @(posedge mclk) peer_snoop <= 2'h0;
        step(4);
        chk("c3 states", core_state_out, 6'h1b);
        chk("c3 clocks", core_clock_stop, 2'h3);
        chk("c3 pkg", package_state, CPPSC_PKG_DEEPSLEEP);
        chk("c3 reads", 8'(rd_cnt - n), 8'h1);
        chk("c3 code", last_code, 3'h3);
        chk("c3 flush", flush_l1_req, 2'h0);
        chk("read idle", power_level_read, 1'b0);
        pulse(2'b11, NR, cppsc_wake_s'(5'h08), 2'h0);
        pulse(2'b01, rq(0, 0, 0, 1, 3'h5), NW, 2'h0);
        pulse(2'b10, rq(0, 1, HINT_C4, 0, 0), NW, 2'h0);
        chk("c4 states", core_state_out, 6'h24);
        chk("c4 pkg", package_state, CPPSC_PKG_DEEPER);
        chk("c4 code", last_code, 3'h4);
        pulse(2'b11, NR, cppsc_wake_s'(5'h01), 2'h0);
        for (int cfg = 1; cfg < 4; cfg += 2) begin
            @(posedge mclk) cstate_config_control <= 2'(cfg);
            pulse(2'b11, rq(0, 0, 0, 1, 3'h6), NW, 2'h0);
            chk("c6 supply", core_supply_off, 2'h3);
            chk("c6 code", last_code, (cfg == 3) ? 3'h6 : 3'h4);
            pulse(2'b11, NR, cppsc_wake_s'(5'h04), 2'h0);
        end
        $display("test deep done");
    endtask

    task automatic t_reset();
        pulse(2'b01, rq(1, 0, 0, 0, 0), NW, 2'h0);
        pulse(2'b10, rq(0, 0, 0, 1, 3'h3), NW, 2'h0);
        @(posedge mclk) resetn <= 1'b0;
        step(2);
        chk("reset states", core_state_out, 6'h0);
        chk("reset break", pending_break_event_n, 1'b1);
        @(posedge mclk) resetn <= 1'b1;
        $display("test reset done");
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        resetn = 1'b0;
        stop_clock_request_n = 1'b1;
        slow = 1'b0;
        core_req = '0;
        core_wake = '0;
        bus_snoop = 2'h0;
        smm_resume_halt = 2'h0;
        peer_snoop = 2'h0;
        misc_enable_config = 15'h691a;
        cstate_config_control = 2'h0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        step(2);
        t_c1();
        @(posedge mclk) slow <= 1'b1;
        t_c2();
        t_deep();
        t_reset();
        wrap_up();
    end
endmodule
